// *** hw/mcd_decoder.sv ***
/*
  Cyclic command decoder and response selector for a single motion axis.
  Assumes a classic Wishbone master, one clock, and a profile generator
  outside that consumes the move and run pulses and profile values.
*/
// Overview of operation
// - command type sits in byte two
// - accept only the eight listed command codes
// - motion commands request response 01,02,03,05,08
// - attribute commands answer with their own code
// - execute only on load bit rising edge
// - error response 14h overrides requested data
// - response codes select position, velocity, torque data
// - command 01 position, 05 torque mode only
// - target position from bytes four to seven
// - payload byte four least, seven most significant
// - move only if enabled, unfaulted; incremental bit
// - move uses programmed accel, decel, velocity
// - target position stored apart from commanded
// - position mode 02 loads scaled max velocity
// - velocity mode 02 starts continuous run
// - direction bit sampled: high forward, low reverse
// - velocity run ramps with programmed acceleration
// - load complete answers each load/start bit rise, legal or not
// - response byte three: type plus axis 001
`timescale 1ns/1ps
module mcd_decoder
(
  // Clock and reset
  input  wire logic            clock_i,
  input  wire logic            rst_n_i,
  // Wishbone slave
  input  wire logic            wb_cyc_i,
  input  wire logic            wb_stb_i,
  input  wire logic            wb_we_i,
  input  wire logic [7:0]      wb_adr_i,
  input  wire logic [3:0]      wb_sel_i,
  input  wire logic [31:0]     wb_dat_i,
  output logic      [31:0]     wb_dat_o,
  output logic                 wb_ack_o,
  // Axis feedback
  input  wire mcd_pkg::mcd_fb_s fb_i,
  input  wire logic            fault_i,
  // Profile generator side
  output logic      [31:0]     target_position_o,
  output logic      [31:0]     max_velocity_register_o,
  output logic      [31:0]     target_velocity_o,
  output logic      [31:0]     accel_o,
  output logic      [31:0]     decel_o,
  output logic                 move_start_o,
  output logic                 move_incremental_o,
  output logic                 run_velocity_forward_cmd_o,
  output logic                 run_velocity_reverse_cmd_o,
  output logic                 load_complete_o
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  mcd_pkg::mcd_cmd_s  cmd_q;          // Command message image
  mcd_pkg::mcd_mode_e mode_q;         // Controller mode
  logic [31:0]        user_unit_scale_q; // Counts to user units, Q16.16
  logic [4:0]         rsp_type_q;     // Active response type
  logic [7:0]         err_code_q;     // Additional error code
  logic [31:0]        rsp_hi_q;       // Response bytes 4..7
  logic [31:0]        tgt_pos_q;      // Stored target position
  logic [31:0]        max_vel_q;      // Max velocity register
  logic [31:0]        tgt_vel_q;      // Run velocity
  logic [31:0]        accel_q;        // Programmed acceleration
  logic [31:0]        decel_q;        // Programmed deceleration
  logic               move_q;         // Point move start pulse
  logic               incr_q;         // Move is relative
  logic               run_fwd_q;      // Forward run pulse
  logic               run_rev_q;      // Reverse run pulse
  logic               load_cmp_q;     // Load complete flag
  logic               ack_q;          // Bus acknowledge
  logic [31:0]        dat_q;          // Bus read data
  logic [31:0]        wmask;          // Byte lane write mask
  logic               wr_stb;         // Write taken this edge
  logic               exec;           // Execute pulse
  logic               ok;             // Command is legal
  logic [7:0]         err_code;       // Reason when not legal
  logic [63:0]        scaled;         // Payload times scale
  logic [31:0]        rsp_lo;         // Response bytes 0..3
  logic [7:0]         cmd_code;       // Byte two command type

  assign cmd_code = cmd_q.cmd_type;

  // ---------------------------------------------------------------
  // Wishbone slave
  // ---------------------------------------------------------------

  // Lane mask from byte selects
  for (genvar g = 0; g < 4; g++)
  begin : g_lane
    assign wmask[8*g +: 8] = {8{wb_sel_i[g]}};
  end

  // Write takes effect on the acknowledging edge
  assign wr_stb = wb_cyc_i & wb_stb_i & wb_we_i & ack_q;

  // One wait state, ack for exactly one cycle
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      ack_q <= 1'b0;
    else
      ack_q <= wb_cyc_i & wb_stb_i & ~ack_q;
  end

  // Command message image
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      cmd_q <= '0;
    else if (wr_stb && wb_adr_i == mcd_pkg::ADR_CMD_LO)
      cmd_q[31:0] <= (cmd_q[31:0] & ~wmask) | (wb_dat_i & wmask);
    else if (wr_stb && wb_adr_i == mcd_pkg::ADR_CMD_HI)
      // Byte four lands in the low lane of the payload
      cmd_q[63:32] <= (cmd_q[63:32] & ~wmask) | (wb_dat_i & wmask);
  end

  // Mode and scale configuration
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      mode_q            <= mcd_pkg::MODE_POSITION;
      user_unit_scale_q <= mcd_pkg::SCALE_RST;
    end
    else if (wr_stb && wb_adr_i == mcd_pkg::ADR_MODE && wb_sel_i[0])
      mode_q <= mcd_pkg::mcd_mode_e'(wb_dat_i[1:0]);
    else if (wr_stb && wb_adr_i == mcd_pkg::ADR_SCALE)
      user_unit_scale_q <= (user_unit_scale_q & ~wmask) | (wb_dat_i & wmask);
  end

  // Read data, unmapped addresses read zero
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      dat_q <= 32'h0000_0000;
    else if (!(wb_cyc_i && wb_stb_i && !ack_q))
      dat_q <= 32'h0000_0000;
    else if (wb_adr_i == mcd_pkg::ADR_CMD_LO)
      dat_q <= cmd_q[31:0];
    else if (wb_adr_i == mcd_pkg::ADR_CMD_HI)
      dat_q <= cmd_q[63:32];
    else if (wb_adr_i == mcd_pkg::ADR_RSP_LO)
      dat_q <= rsp_lo;
    else if (wb_adr_i == mcd_pkg::ADR_RSP_HI)
      dat_q <= rsp_hi_q;
    else if (wb_adr_i == mcd_pkg::ADR_MODE)
      dat_q <= {30'h0, mode_q};
    else if (wb_adr_i == mcd_pkg::ADR_SCALE)
      dat_q <= user_unit_scale_q;
    else if (wb_adr_i == mcd_pkg::ADR_TGT_POS)
      dat_q <= tgt_pos_q;
    else if (wb_adr_i == mcd_pkg::ADR_MAX_VEL)
      dat_q <= max_vel_q;
    else
      dat_q <= 32'h0000_0000;
  end

  // ---------------------------------------------------------------
  // Command decode
  // ---------------------------------------------------------------

  // Master drops load bit before new data, so each rise is one command
  mcd_rise_det u_rise
  (
    .clock_i (clock_i),
    .rst_n_i (rst_n_i),
    .level_i (cmd_q.ctrl[mcd_pkg::BIT_LOAD]),
    .rise_o  (exec)
  );

  // Legality of code, response type and mode
  mcd_validate u_val
  (
    .cmd_type_i (cmd_code),
    .rsp_type_i (cmd_q.rsp_sel[4:0]),
    .mode_i     (mode_q),
    .ok_o       (ok),
    .err_code_o (err_code)
  );

  // Counts per second into user units
  assign scaled = $signed(cmd_q.payload) * $signed(user_unit_scale_q);

  // Response type latched at execution
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rsp_type_q <= mcd_pkg::RSP_A_POS;
      err_code_q <= 8'h00;
    end
    else if (exec && !ok)
    begin
      // Error reply replaces whatever was requested
      rsp_type_q <= mcd_pkg::RSP_ERR;
      err_code_q <= err_code;
    end
    else if (exec)
      rsp_type_q <= cmd_q.rsp_sel[4:0];
  end

  // Target position held apart from trajectory position
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      tgt_pos_q <= 32'h0000_0000;
    else if (exec && ok && cmd_code == 8'h01)
      tgt_pos_q <= cmd_q.payload;
  end

  // Point move start, gated by enable and fault
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      move_q <= 1'b0;
      incr_q <= 1'b0;
    end
    else
    begin
      move_q <= exec && ok && cmd_code == 8'h01 && !fault_i
                && cmd_q.ctrl[mcd_pkg::BIT_ENABLE];
      if (exec && ok && cmd_code == 8'h01)
        incr_q <= cmd_q.ctrl[mcd_pkg::BIT_INCR];
    end
  end

  // Target velocity: max velocity or continuous run
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      max_vel_q <= 32'h0000_0000;
      tgt_vel_q <= 32'h0000_0000;
      run_fwd_q <= 1'b0;
      run_rev_q <= 1'b0;
    end
    else
    begin
      run_fwd_q <= 1'b0;
      run_rev_q <= 1'b0;
      if (exec && ok && cmd_code == 8'h02 && mode_q == mcd_pkg::MODE_POSITION)
        max_vel_q <= scaled[mcd_pkg::SCALE_FRAC +: 32];
      else if (exec && ok && cmd_code == 8'h02)
      begin
        // Direction sampled on the load edge
        tgt_vel_q <= cmd_q.payload;
        run_fwd_q <= cmd_q.ctrl[mcd_pkg::BIT_DIR];
        run_rev_q <= !cmd_q.ctrl[mcd_pkg::BIT_DIR];
      end
    end
  end

  // Programmed ramp rates used by both move kinds
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      accel_q <= 32'h0000_0000;
      decel_q <= 32'h0000_0000;
    end
    else if (exec && ok && cmd_code == 8'h03)
      accel_q <= scaled[mcd_pkg::SCALE_FRAC +: 32];
    else if (exec && ok && cmd_code == 8'h04)
      decel_q <= scaled[mcd_pkg::SCALE_FRAC +: 32];
  end

  // Load complete: set on every execute pulse, legal or not, cleared when load bit drops
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      load_cmp_q <= 1'b0;
    else if (exec)
      load_cmp_q <= 1'b1;
    else if (!cmd_q.ctrl[mcd_pkg::BIT_LOAD])
      load_cmp_q <= 1'b0;
  end

  // ---------------------------------------------------------------
  // Response message
  // ---------------------------------------------------------------

  // Byte two status, byte three type and axis
  assign rsp_lo = {mcd_pkg::AXIS_NUM, rsp_type_q, load_cmp_q, 7'h00, 16'h0000};

  // Data bytes follow live feedback for the latched type
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      rsp_hi_q <= 32'h0000_0000;
    else if (rsp_type_q == mcd_pkg::RSP_ERR)
      rsp_hi_q <= {16'h0000, err_code_q, mcd_pkg::ERR_GENERAL};
    else if (rsp_type_q == mcd_pkg::RSP_A_POS)
      rsp_hi_q <= fb_i.act_pos;
    else if (rsp_type_q == mcd_pkg::RSP_C_POS)
      rsp_hi_q <= fb_i.cmd_pos;
    else if (rsp_type_q == mcd_pkg::RSP_A_VEL)
      rsp_hi_q <= fb_i.act_vel;
    else if (rsp_type_q == mcd_pkg::RSP_TORQ)
      rsp_hi_q <= fb_i.torque;
    else if (rsp_type_q == mcd_pkg::RSP_REG)
      rsp_hi_q <= fb_i.reg_pos;
    else
      rsp_hi_q <= 32'h0000_0000;
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign wb_ack_o                   = ack_q;
  assign wb_dat_o                   = dat_q;
  assign target_position_o          = tgt_pos_q;
  assign max_velocity_register_o    = max_vel_q;
  assign target_velocity_o          = tgt_vel_q;
  assign accel_o                    = accel_q;
  assign decel_o                    = decel_q;
  assign move_start_o               = move_q;
  assign move_incremental_o         = incr_q;
  assign run_velocity_forward_cmd_o = run_fwd_q;
  assign run_velocity_reverse_cmd_o = run_rev_q;
  assign load_complete_o            = load_cmp_q;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  localparam logic [1:0] MODE_VEL_C = 2'b01; // Velocity mode for checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  exec_edge_a: assert property (exec |-> cmd_q.ctrl[0] && !$past(cmd_q.ctrl[0]))
    else $error("execute without load bit rising");
  axis_field_a: assert property (rsp_lo[31:29] == 3'h1)
    else $error("response axis number not one");
  err_replace_a: assert property (exec && !ok |=> rsp_type_q == 5'h14)
    else $error("error response not selected");
  bad_code_a: assert property (exec && cmd_code == 8'h06 |=> rsp_type_q == 5'h14)
    else $error("unsupported code accepted");
  attr_echo_a: assert property (exec && ok && cmd_code == 8'h1B |=> rsp_type_q == 5'h1B)
    else $error("attribute reply code wrong");
  pos_move_a: assert property (exec && ok && cmd_code == 8'h01 && !fault_i && cmd_q.ctrl[7]
    |=> move_start_o && target_position_o == $past(cmd_q.payload))
    else $error("target position move not started");
  fault_hold_a: assert property (exec && fault_i |=> !move_start_o)
    else $error("move started while faulted");
  vel_dir_a: assert property (exec && ok && cmd_code == 8'h02 && mode_q == MODE_VEL_C
    |=> run_velocity_forward_cmd_o == $past(cmd_q.ctrl[3]) && run_velocity_reverse_cmd_o
        != $past(cmd_q.ctrl[3]) ##1 !run_velocity_forward_cmd_o)
    else $error("run direction or pulse wrong");
  maxvel_only_a: assert property (exec && ok && cmd_code == 8'h02 && mode_q == 2'b00
    |=> !run_velocity_forward_cmd_o && !run_velocity_reverse_cmd_o)
    else $error("position mode velocity command started a run");
  load_done_a: assert property (exec |=> load_complete_o ##1 1'b1)
    else $error("load complete not set");
  mode_gate_a: assert property (exec && cmd_code == 8'h05 && mode_q != 2'b10
    |=> rsp_type_q == 5'h14)
    else $error("torque command accepted outside torque mode");

  pos_cmd_c: cover property (exec && ok && cmd_code == 8'h01 ##1 move_start_o);
  vel_run_c: cover property (exec && ok && cmd_code == 8'h02 && mode_q == 2'b01);
  err_rsp_c: cover property (exec && !ok);
  bus_rd_c:  cover property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h0C);

endmodule // mcd_decoder

// *** hw/mcd_pkg.sv ***
/*
  Shared constants and carrier types for the motion command decoder.
  Assumes a single clock domain and a classic Wishbone register bus.
*/
package mcd_pkg;

  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] ADR_CMD_LO  = 8'h00; // Command bytes 0..3
  localparam logic [7:0] ADR_CMD_HI  = 8'h04; // Command bytes 4..7
  localparam logic [7:0] ADR_RSP_LO  = 8'h08; // Response bytes 0..3
  localparam logic [7:0] ADR_RSP_HI  = 8'h0C; // Response bytes 4..7
  localparam logic [7:0] ADR_MODE    = 8'h10; // Controller mode
  localparam logic [7:0] ADR_SCALE   = 8'h14; // User unit scale, Q16.16
  localparam logic [7:0] ADR_TGT_POS = 8'h18; // Stored target position
  localparam logic [7:0] ADR_MAX_VEL = 8'h1C; // Max velocity register

  // ---------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------
  localparam int         BIT_LOAD       = 0;      // Load/start, byte 0
  localparam int         BIT_INCR       = 2;      // Incremental, byte 0
  localparam int         BIT_DIR        = 3;      // Direction, byte 0
  localparam int         BIT_ENABLE     = 7;      // Enable, byte 0
  localparam int         SCALE_FRAC     = 16;     // Scale fraction bits
  localparam logic [2:0] AXIS_NUM       = 3'h1;   // Fixed axis number
  localparam logic [31:0] SCALE_RST     = 32'h0001_0000; // Unity scale
  localparam logic [7:0] ERR_GENERAL    = 8'h1F;  // General error code
  localparam logic [7:0] ERR_BAD_CMD    = 8'h01;  // Unsupported command
  localparam logic [7:0] ERR_BAD_RSP    = 8'h02;  // Bad response type
  localparam logic [7:0] ERR_BAD_MODE   = 8'h03;  // Wrong mode

  // ---------------------------------------------------------------
  // Enumerations
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_POSITION = 2'b00,
    MODE_VELOCITY = 2'b01,
    MODE_TORQUE   = 2'b10
  } mcd_mode_e;

  typedef enum logic [4:0] {
    CMD_TGT_POS = 5'h01, CMD_TGT_VEL = 5'h02, CMD_ACCEL = 5'h03,
    CMD_DECEL   = 5'h04, CMD_TORQUE  = 5'h05, CMD_SUPER = 5'h1A,
    CMD_CTRL    = 5'h1B, CMD_PARAM   = 5'h1F, RSP_ACT_POS = 5'h00
  } mcd_code_e;

  localparam logic [4:0] RSP_A_POS = 5'h01; // Actual position
  localparam logic [4:0] RSP_C_POS = 5'h02; // Commanded position
  localparam logic [4:0] RSP_A_VEL = 5'h03; // Actual velocity
  localparam logic [4:0] RSP_TORQ  = 5'h05; // Actual torque
  localparam logic [4:0] RSP_REG   = 5'h08; // Registration capture
  localparam logic [4:0] RSP_ERR   = 5'h14; // Error response

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [31:0] payload;  // Bytes 7..4, byte 4 least significant
    logic [7:0]  rsp_sel;  // Byte 3
    logic [7:0]  cmd_type; // Byte 2
    logic [7:0]  spare;    // Byte 1
    logic [7:0]  ctrl;     // Byte 0
  } mcd_cmd_s;

  typedef struct packed {
    logic [31:0] act_pos;  // Actual position, counts
    logic [31:0] cmd_pos;  // Commanded position from trajectory
    logic [31:0] act_vel;  // Actual velocity, counts per second
    logic [31:0] torque;   // Actual torque, 1000 = 100 percent
    logic [31:0] reg_pos;  // Captured registration position
  } mcd_fb_s;

endpackage

// *** hw/mcd_rise_det.sv ***
/*
  Rising edge detector for the load/start bit.
  Assumes the level input is synchronous to clock_i.
*/
`timescale 1ns/1ps
module mcd_rise_det
(
  // Clock and reset
  input  wire logic clock_i,
  input  wire logic rst_n_i,
  // Level in, pulse out
  input  wire logic level_i,
  output logic      rise_o
);

  logic prev_q; // Level seen on the last edge

  // Remember the previous level
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      prev_q <= 1'b0;
    else
      prev_q <= level_i;
  end

  // One pulse on a low to high change only
  assign rise_o = level_i & ~prev_q;

endmodule // mcd_rise_det

// *** hw/mcd_validate.sv ***
/*
  Combinational legality check of command type, response type and mode.
  Assumes inputs are stable while the execute pulse is high.
*/
`timescale 1ns/1ps
module mcd_validate
(
  // Command fields
  input  wire logic [7:0] cmd_type_i,
  input  wire logic [4:0] rsp_type_i,
  input  wire logic [1:0] mode_i,
  // Verdict
  output logic            ok_o,
  output logic [7:0]      err_code_o
);

  logic known;   // Supported command type
  logic attr;    // Attribute or parameter command
  logic rsp_ok;  // Response type legal for command
  logic mode_ok; // Command legal in this mode

  always_comb
  begin
    known   = (cmd_type_i >= 8'h01 && cmd_type_i <= 8'h05) || cmd_type_i == 8'h1A
              || cmd_type_i == 8'h1B || cmd_type_i == 8'h1F;
    attr    = cmd_type_i[4];
    // Attribute commands answer with their own code only
    if (attr)
      rsp_ok = ({3'h0, rsp_type_i} == cmd_type_i);
    else
      rsp_ok = rsp_type_i == mcd_pkg::RSP_A_POS || rsp_type_i == mcd_pkg::RSP_C_POS
               || rsp_type_i == mcd_pkg::RSP_A_VEL || rsp_type_i == mcd_pkg::RSP_TORQ
               || rsp_type_i == mcd_pkg::RSP_REG;
    // Mode restrictions per command
    if (attr)
      mode_ok = 1'b1;
    else if (cmd_type_i == 8'h01)
      mode_ok = mode_i == mcd_pkg::MODE_POSITION;
    else if (cmd_type_i == 8'h05)
      mode_ok = mode_i == mcd_pkg::MODE_TORQUE;
    else
      mode_ok = mode_i == mcd_pkg::MODE_POSITION || mode_i == mcd_pkg::MODE_VELOCITY;
    ok_o = known && rsp_ok && mode_ok;
    if (!known)
      err_code_o = mcd_pkg::ERR_BAD_CMD;
    else if (!rsp_ok)
      err_code_o = mcd_pkg::ERR_BAD_RSP;
    else
      err_code_o = mcd_pkg::ERR_BAD_MODE;
  end

endmodule // mcd_validate

// *** testbench/mcd_axis_model.sv ***
/*
  Axis feedback model for the motion command decoder.
  Assumes move pulse, incremental flag and target come from the decoder.
*/
`timescale 1ns/1ps
module mcd_axis_model
#(
  parameter logic [31:0] P_ACT = 32'h0000_0000, // Actual position
  parameter logic [31:0] P_VEL = 32'h0000_0000, // Actual velocity
  parameter logic [31:0] P_TRQ = 32'h0000_0000, // Actual torque
  parameter logic [31:0] P_REG = 32'h0000_0000  // Registration capture
)
(
  // Clock and reset
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  // Move request
  input  wire logic        move_i,
  input  wire logic        incr_i,
  input  wire logic [31:0] tgt_i,
  // Feedback
  output mcd_pkg::mcd_fb_s fb_o
);
  logic [31:0] cmd_q; // Trajectory end point

  // Point move sets the commanded position at once
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      cmd_q <= 32'h0;
    else if (move_i)
      cmd_q <= incr_i ? cmd_q + tgt_i : tgt_i;
  end

  assign fb_o = {P_ACT, cmd_q, P_VEL, P_TRQ, P_REG};
endmodule // mcd_axis_model

// *** testbench/tb_top.sv ***
/*
  Self-checking bench for the decoder over Wishbone.
  Assumes mcd_pkg and the axis model are compiled first.
*/
`timescale 1ns/1ps
module tb_top;
  // ------------------------------------------------
  // Signals
  // ------------------------------------------------
  localparam logic [31:0] ACT = 32'h0001_2345; // Feedback values
  localparam logic [31:0] VEL = 32'h0000_4E20;
  localparam logic [31:0] TRQ = 32'h0000_03E8;
  localparam logic [31:0] REG = 32'hFFFF_FF38;
  logic        clock_i, rst_n_i, cyc, stb, we, ack, fault, mv, inc, fwd, rev;
  logic [7:0]  adr;
  logic [31:0] dat, dat_o, tpos, tvel, cpos, p, acc, dec;
  logic [63:0] rn;
  logic [63:0] rq[$];  // Expected reads, mask above value
  logic [34:0] pq[$];  // Expected pulses and value
  logic [4:0]  rt[5] = '{5'h01, 5'h02, 5'h03, 5'h05, 5'h08};
  logic [23:0] et[3] = '{24'h06_01_01, 24'h1A_01_02, 24'h05_01_03};
  int          fails, n_tests, i;
  mcd_pkg::mcd_fb_s fb;

  mcd_decoder DUT (.clock_i(clock_i), .rst_n_i(rst_n_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .fb_i(fb), .fault_i(fault), .target_position_o(tpos),
    .max_velocity_register_o(), .target_velocity_o(tvel), .accel_o(acc), .decel_o(dec),
    .move_start_o(mv), .move_incremental_o(inc), .run_velocity_forward_cmd_o(fwd),
    .run_velocity_reverse_cmd_o(rev), .load_complete_o());
  mcd_axis_model #(.P_ACT(ACT), .P_VEL(VEL), .P_TRQ(TRQ), .P_REG(REG)) AXIS (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .move_i(mv), .incr_i(inc), .tgt_i(tpos),
    .fb_o(fb));

  // ------------------------------------------------
  // Helpers
  // ------------------------------------------------
  function automatic logic [31:0] lo(input logic [4:0] t);
    return {3'h1, t, 1'b1, 23'h0};
  endfunction
  function automatic logic [31:0] fbv(input logic [4:0] r);
    case (r)
      5'h01: return ACT;
      5'h02: return cpos;
      5'h03: return VEL;
      5'h05: return TRQ;
      default: return REG;
    endcase
  endfunction
  task automatic chk(input logic [34:0] e, input logic [34:0] g);
    n_tests++;
    if (g !== e)
    begin
      fails++;
      $display("wrong value t=%0t exp %h got %h", $time, e, g);
    end
  endtask
  // Register and level results
  task automatic chk_rd(input logic [31:0] e, input logic [31:0] g);
    chk({3'h0, e}, {3'h0, g});
  endtask
  // Classic single cycle, held until ack is seen
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d;
    do @(posedge clock_i); while (ack !== 1'b1);
    cyc <= 1'b0; stb <= 1'b0;
    @(posedge clock_i);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [31:0] m = 32'hFFFF_FFFF);
    rq.push_back({m, e & m});
    bus(1'b0, a, 32'h0);
  endtask
  // Payload, then bytes 3..0 with load low, then load high
  task automatic cmd(input logic [7:0] c, t, r, input logic [31:0] d);
    bus(1'b1, 8'h04, d);
    bus(1'b1, 8'h00, {r, t, 8'h00, c});
    bus(1'b1, 8'h00, {r, t, 8'h00, c | 8'h01});
    repeat (3) @(posedge clock_i);
  endtask
  task automatic summarize;
    if (pq.size() != 0) fails++;
    if (fails == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ------------------------------------------------
  // Monitors and stimulus
  // ------------------------------------------------
  always @(posedge clock_i)
  begin
    if (ack && cyc && !we)
    begin
      rn = rq.pop_front();
      chk_rd(rn[31:0], dat_o & rn[63:32]);
    end
    if (mv | fwd | rev)
      chk(pq.size() ? pq.pop_front() : 35'h0, {mv, fwd, rev, mv ? tpos : tvel});
  end
  initial
  begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end
  initial
  begin
    repeat (20000) @(posedge clock_i);
    fails++;
    summarize();
  end
  initial
  begin
    void'($urandom(32'hDA0C7DC8));
    {rst_n_i, cyc, stb, we, fault, adr, dat, cpos} = '0;
    repeat (2) @(posedge clock_i);
    rst_n_i <= 1'b1;
    @(posedge clock_i);
    p = $urandom; pq.push_back({3'b100, p}); cmd(8'h80, 8'h01, 8'h01, p); cpos = p;
    rd(8'h08, lo(5'h01));
    rd(8'h18, p);
    p = $urandom; pq.push_back({3'b100, p}); cmd(8'h84, 8'h01, 8'h01, p); cpos += p;
    fault <= 1'b1; cmd(8'h80, 8'h01, 8'h01, ~p); fault <= 1'b0;
    p = $urandom; cmd(8'h00, 8'h01, 8'h01, p); rd(8'h18, p);
    for (i = 0; i < 5; i++)
    begin
      p = $urandom & 32'h00FF_FFFF;
      cmd(8'h00, i[0] ? 8'h04 : 8'h03, {3'h0, rt[i]}, p);
      chk_rd(p, i[0] ? dec : acc);
      rd(8'h08, lo(rt[i]));
      rd(8'h0C, fbv(rt[i]));
    end
    bus(1'b1, 8'h14, 32'h0002_0000);
    p = $urandom & 32'h00FF_FFFF; cmd(8'h00, 8'h02, 8'h01, p); rd(8'h1C, p << 1);
    for (i = 0; i < 3; i++)
    begin
      cmd(8'h80, et[i][23:16], et[i][15:8], $urandom);
      rd(8'h08, lo(5'h14), 32'hFF00_0000); rd(8'h0C, {16'h0, et[i][7:0], 8'h1F});
    end
    cmd(8'h00, 8'h1B, 8'h1B, $urandom); rd(8'h08, lo(5'h1B)); rd(8'h0C, 32'h0);
    bus(1'b1, 8'h10, 32'h1);
    p = $urandom; pq.push_back({3'b010, p}); cmd(8'h08, 8'h02, 8'h05, p);
    rd(8'h08, lo(5'h05));
    p = $urandom; pq.push_back({3'b001, p}); cmd(8'h00, 8'h02, 8'h05, p);
    bus(1'b1, 8'h00, 32'h0502_0001); repeat (3) @(posedge clock_i);
    cmd(8'h80, 8'h01, 8'h01, p); rd(8'h0C, {16'h0, 8'h03, 8'h1F});
    bus(1'b1, 8'h10, 32'h2);
    cmd(8'h00, 8'h05, 8'h05, 32'h0000_03E8); rd(8'h08, lo(5'h05)); rd(8'h0C, TRQ);
    rst_n_i <= 1'b0; @(posedge clock_i);
    rst_n_i <= 1'b1; @(posedge clock_i);
    rd(8'h08, {3'h1, 5'h01, 24'h0}); rd(8'h10, 32'h0); rd(8'h14, 32'h0001_0000);
    rd(8'h20, 32'h0);
    repeat (4) @(posedge clock_i);
    summarize();
  end
endmodule // tb_top
